// file: logic/spcc_pkg.sv
// Package for the serial port control and configuration block
package spcc_pkg;
    localparam logic [3:0] SPCC_OFS_MAIN = 4'h0;
    localparam logic [3:0] SPCC_OFS_FMT = 4'h4;
    localparam logic [3:0] SPCC_OFS_EXT = 4'h8;
    localparam logic [3:0] SPCC_OFS_LINE = 4'hc;
    localparam logic [31:0] SPCC_RST_VAL = 32'h0;
    // Main, format and extension registers: writable-at-any-time bits and locked bits
    localparam logic [31:0] SPCC_MAIN_LOCK = 32'h03ff_9e00;
    localparam logic [31:0] SPCC_MAIN_MASK = 32'h0fff_ffff;
    localparam logic [31:0] SPCC_FMT_LOCK = 32'h000f_ff30;
    localparam logic [31:0] SPCC_FMT_MASK = 32'hff8f_ff70;
    localparam logic [31:0] SPCC_EXT_LOCK = 32'h0030_fb3e;
    localparam logic [31:0] SPCC_EXT_MASK = 32'h007e_ffff;
    localparam logic [31:0] SPCC_ADDR_FIELD = 32'hff00_0000;
    localparam int SPCC_B_UEN = 0;
    localparam int SPCC_B_SLEEP_WAKE_ENABLE = 1;
    localparam int SPCC_B_REN = 2;
    localparam int SPCC_B_TEN = 3;
    localparam int SPCC_B_IDLE_IRQ_EN = 4;
    localparam int SPCC_B_RXIE = 5;
    localparam int SPCC_B_TX_DONE_IRQ_EN = 6;
    localparam int SPCC_B_TX_EMPTY_IRQ_EN = 7;
    localparam int SPCC_B_PERIE = 8;
    localparam int SPCC_B_PODD = 9;
    localparam int SPCC_B_PON = 10;
    localparam int SPCC_B_WAKE = 11;
    localparam int SPCC_B_WL = 12;
    localparam int SPCC_B_MUTE = 13;
    localparam int SPCC_B_CHAR_MATCH_IRQ_EN = 14;
    localparam int SPCC_B_OVS = 15;
    localparam int SPCC_B_LAG = 16;
    localparam int SPCC_B_LEAD = 21;
    localparam int SPCC_B_RX_TIMEOUT_IRQ_EN = 26;
    localparam int SPCC_B_BLOCK_END_IRQ_EN = 27;
    localparam int SPCC_B_ADDRESS_WIDTH_SEL = 4;
    localparam int SPCC_B_BREAK_LENGTH_SEL = 5;
    localparam int SPCC_B_LBDIE = 6;
    localparam int SPCC_B_LAST_BIT_CLOCK_OUT = 8;
    localparam int SPCC_B_CPH = 9;
    localparam int SPCC_B_CPL = 10;
    localparam int SPCC_B_CKEN = 11;
    localparam int SPCC_B_STB = 12;
    localparam int SPCC_B_SWAP = 15;
    localparam int SPCC_B_RX_LEVEL_INVERT = 16;
    localparam int SPCC_B_TX_LEVEL_INVERT = 17;
    localparam int SPCC_B_DATA_VALUE_INVERT = 18;
    localparam int SPCC_B_MSB_FIRST_SEL = 19;
    localparam int SPCC_B_ADDR = 24;
    localparam int SPCC_B_DPOL = 15;
    localparam int SPCC_B_DON = 14;
    localparam logic [4:0] SPCC_OVS16 = 5'd16;
    localparam logic [4:0] SPCC_OVS8 = 5'd8;
    localparam logic [3:0] SPCC_BRK10 = 4'd10;
    localparam logic [3:0] SPCC_BRK11 = 4'd11;
    localparam logic [3:0] SPCC_BITS8 = 4'd8;
    localparam logic [3:0] SPCC_BITS9 = 4'd9;
    localparam logic [15:0] SPCC_DIV_RST = 16'h0001;
    // Line-side status inputs from the frame engine
    typedef struct packed {
        logic rx_ready_flag;
        logic overrun_flag;
        logic tx_empty_flag;
        logic tx_done_flag;
        logic parity_fault_flag;
        logic idle_flag;
        logic break_flag;
        logic char_match_flag;
        logic timeout_flag;
        logic block_end_flag;
    } spcc_flags_type;
    typedef enum logic [1:0] {
        SPCC_DE_IDLE, SPCC_DE_LEAD, SPCC_DE_BUSY, SPCC_DE_LAG
    } spcc_de_state_type;
    typedef struct packed {
        logic [31:0] main_q;
        logic [31:0] fmt_q;
        logic [31:0] ext_q;
        logic [15:0] div_q;
        logic [15:0] tick_cnt_q;
        logic [4:0] de_cnt_q;
        spcc_de_state_type de_st_q;
        logic aw_got_q;
        logic w_got_q;
        logic [3:0] aw_addr_q;
        logic [31:0] wdata_q;
        logic [3:0] wstrb_q;
        logic bvalid_q;
        logic [1:0] bresp_q;
        logic rvalid_q;
        logic [31:0] rdata_q;
        logic [1:0] rresp_q;
        logic irq_q;
        logic de_pin_q;
        logic tx_pin_q;
        logic ck_pin_q;
        logic [1:0] rx_sync_q;
        logic rx_bit_q;
        logic oe_q;
        logic tick_q;
        logic wake_q;
        logic mute_q;
        logic match_q;
        logic tx_gate_q;
        logic rx_on_q;
    } spcc_state_type;
endpackage : spcc_pkg

// file: logic/spcc_top.sv
// Serial port control and configuration layer with AXI4-Lite slave
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module spcc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire spcc_pkg::spcc_flags_type flags,
    input wire logic [15:0] bit_divider,
    input wire logic clk_src_ok,
    input wire logic tx_frame_req,
    input wire logic tx_frame_busy,
    input wire logic tx_serial_bit,
    input wire logic sync_clk_raw,
    input wire logic rx_frame_done,
    input wire logic [8:0] rx_frame_data,
    input wire logic line_idle,
    input wire logic rx_pin,
    input wire logic tx_pin_in,
    output logic tx_pin,
    output logic tx_pin_oe,
    output logic rx_data_bit,
    output logic ck_pin,
    output logic transceiver_drive_enable,
    output logic tx_start_ok,
    output logic irq,
    output logic sleep_wake,
    output logic mute_active,
    output logic addr_match,
    output logic receiver_on,
    output logic sample_tick
);
    import spcc_pkg::*;

    spcc_state_type s_q;
    spcc_state_type s_d;
    logic tick_r;

    function automatic logic [31:0] spcc_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb,
        input logic [31:0] wmask
    );
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        spcc_merge = (old_v & ~m) | (new_v & m);
    endfunction : spcc_merge

    function automatic logic [31:0] spcc_read(
        input logic [3:0] a,
        input spcc_state_type s
    );
        case (a)
            SPCC_OFS_MAIN: spcc_read = s.main_q;
            SPCC_OFS_FMT: spcc_read = s.fmt_q;
            SPCC_OFS_EXT: spcc_read = s.ext_q;
            SPCC_OFS_LINE: spcc_read = {16'h0,
                s.fmt_q[SPCC_B_BREAK_LENGTH_SEL] ? SPCC_BRK11 : SPCC_BRK10,
                s.main_q[SPCC_B_WL] ? SPCC_BITS9 : SPCC_BITS8,
                s.irq_q, s.match_q, s.mute_q, s.wake_q, s.tx_gate_q,
                s.rx_on_q, 2'h0};
            default: spcc_read = 32'h0;
        endcase
    endfunction : spcc_read

    always_comb
    begin
        logic en;
        logic [31:0] lock_m;
        logic [31:0] lock_f;
        logic [7:0] cmp_m;
        logic ints;
        logic wr;
        logic [4:0] ovs;
        logic [15:0] per;
        logic sel_rx;
        logic wr_ok;
        en = s_q.main_q[SPCC_B_UEN];
        lock_m = SPCC_MAIN_MASK & ~(en ? SPCC_MAIN_LOCK : 32'h0);
        lock_f = SPCC_FMT_MASK & ~(en ? SPCC_FMT_LOCK : 32'h0);
        cmp_m = 8'h0;
        ints = 1'b0;
        wr = 1'b0;
        ovs = SPCC_OVS16;
        per = 16'h0;
        sel_rx = 1'b0;
        wr_ok = 1'b0;
        s_d = s_q;
        // Write channels accepted independently, held until both seen
        if (s_axi_awvalid && !s_q.aw_got_q)
        begin
            s_d.aw_got_q = 1'b1;
            s_d.aw_addr_q = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got_q)
        begin
            s_d.w_got_q = 1'b1;
            s_d.wdata_q = s_axi_wdata;
            s_d.wstrb_q = s_axi_wstrb;
        end
        wr = s_q.aw_got_q && s_q.w_got_q && !s_q.bvalid_q;
        if (wr)
        begin
            s_d.aw_got_q = 1'b0;
            s_d.w_got_q = 1'b0;
            s_d.bvalid_q = 1'b1;
            wr_ok = s_q.aw_addr_q[1:0] == 2'b00 &&
                s_q.aw_addr_q <= SPCC_OFS_EXT;
            s_d.bresp_q = wr_ok ? 2'b00 : 2'b10;
            case (s_q.aw_addr_q)
                SPCC_OFS_MAIN: s_d.main_q = spcc_merge(s_q.main_q,
                    s_q.wdata_q, s_q.wstrb_q, lock_m);
                SPCC_OFS_FMT:
                begin
                    if (en && s_q.main_q[SPCC_B_REN])
                        lock_f = lock_f & ~SPCC_ADDR_FIELD;
                    s_d.fmt_q = spcc_merge(s_q.fmt_q, s_q.wdata_q,
                        s_q.wstrb_q, lock_f);
                end
                SPCC_OFS_EXT: s_d.ext_q = spcc_merge(s_q.ext_q,
                    s_q.wdata_q, s_q.wstrb_q,
                    SPCC_EXT_MASK & ~(en ? SPCC_EXT_LOCK : 32'h0));
                default: s_d.bresp_q = 2'b10;
            endcase
        end
        if (s_q.bvalid_q && s_axi_bready)
            s_d.bvalid_q = 1'b0;
        if (s_axi_arvalid && !s_q.rvalid_q)
        begin
            s_d.rvalid_q = 1'b1;
            s_d.rdata_q = spcc_read(s_axi_araddr, s_q);
            s_d.rresp_q = (s_axi_araddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
        end
        else if (s_q.rvalid_q && s_axi_rready)
            s_d.rvalid_q = 1'b0;

        // Sample tick: bit period split by oversampling ratio
        ovs = s_q.main_q[SPCC_B_OVS] ? SPCC_OVS8 : SPCC_OVS16;
        s_d.div_q = (bit_divider == 16'h0) ? SPCC_DIV_RST : bit_divider;
        // Constant divisors keep this a shift, not a divider
        per = (ovs == SPCC_OVS8) ? s_q.div_q / 16'(SPCC_OVS8)
            : s_q.div_q / 16'(SPCC_OVS16);
        // Bit periods shorter than the ratio tick every clock
        if (per == 16'h0)
            per = SPCC_DIV_RST;
        tick_r = 1'b0;
        if (!en)
            s_d.tick_cnt_q = 16'h0;
        else if (s_q.tick_cnt_q + 16'h1 >= per)
        begin
            s_d.tick_cnt_q = 16'h0;
            tick_r = 1'b1;
        end
        else
            s_d.tick_cnt_q = s_q.tick_cnt_q + 16'h1;

        // Drive enable sequencing, counts in sample ticks
        case (s_q.de_st_q)
            SPCC_DE_IDLE:
                if (en && s_q.ext_q[SPCC_B_DON] && tx_frame_req)
                begin
                    s_d.de_st_q = SPCC_DE_LEAD;
                    s_d.de_cnt_q = s_q.main_q[SPCC_B_LEAD +: 5];
                end
            SPCC_DE_LEAD:
                if (s_q.de_cnt_q == 5'd0)
                    s_d.de_st_q = SPCC_DE_BUSY;
                else if (tick_r)
                    s_d.de_cnt_q = s_q.de_cnt_q - 5'd1;
            SPCC_DE_BUSY:
                if (!tx_frame_busy && !tx_frame_req)
                begin
                    s_d.de_st_q = SPCC_DE_LAG;
                    s_d.de_cnt_q = s_q.main_q[SPCC_B_LAG +: 5];
                end
            SPCC_DE_LAG:
                if (s_q.de_cnt_q == 5'd0)
                    s_d.de_st_q = SPCC_DE_IDLE;
                else if (tick_r)
                    s_d.de_cnt_q = s_q.de_cnt_q - 5'd1;
            default: s_d.de_st_q = SPCC_DE_IDLE;
        endcase
        if (!en)
            s_d.de_st_q = SPCC_DE_IDLE;
        // Active level chosen by polarity bit
        s_d.de_pin_q = (s_d.de_st_q != SPCC_DE_IDLE) ^
            s_q.ext_q[SPCC_B_DPOL];
        s_d.tx_gate_q = en && s_q.main_q[SPCC_B_TEN] &&
            (!s_q.ext_q[SPCC_B_DON] || s_q.de_st_q == SPCC_DE_BUSY);

        // Pins: swap, level inversion; tx pin idle high while the port is disabled
        sel_rx = s_q.fmt_q[SPCC_B_SWAP] ? tx_pin_in : rx_pin;
        s_d.rx_sync_q = {s_q.rx_sync_q[0], sel_rx};
        s_d.rx_bit_q = s_q.rx_sync_q[1] ^ s_q.fmt_q[SPCC_B_RX_LEVEL_INVERT];
        s_d.tx_pin_q = en ? (tx_serial_bit ^ s_q.fmt_q[SPCC_B_TX_LEVEL_INVERT])
            : 1'b1;
        // Synchronous clock idles at polarity level outside frames
        s_d.ck_pin_q = (en && s_q.fmt_q[SPCC_B_CKEN] && tx_frame_busy)
            ? (sync_clk_raw ^ s_q.fmt_q[SPCC_B_CPL])
            : s_q.fmt_q[SPCC_B_CPL];
        s_d.rx_on_q = en && s_q.main_q[SPCC_B_REN];

        // Mute wake-up address compare width: 4 bits, or 7/8 by word length; addr_match compares all 8
        if (!s_q.fmt_q[SPCC_B_ADDRESS_WIDTH_SEL])
            cmp_m = 8'h0f;
        else
            cmp_m = s_q.main_q[SPCC_B_WL] ? 8'hff : 8'h7f;
        s_d.match_q = 1'b0;
        if (s_q.rx_on_q && rx_frame_done)
        begin
            if (s_q.mute_q && s_q.main_q[SPCC_B_WAKE] &&
                rx_frame_data[s_q.main_q[SPCC_B_WL] ? 8 : 7] &&
                ((rx_frame_data[7:0] ^ s_q.fmt_q[SPCC_B_ADDR +: 8])
                & cmp_m) == 8'h0)
                s_d.mute_q = 1'b0;
            if (!s_q.mute_q &&
                rx_frame_data[7:0] == s_q.fmt_q[SPCC_B_ADDR +: 8])
                s_d.match_q = 1'b1;
        end
        if (s_q.mute_q && !s_q.main_q[SPCC_B_WAKE] && line_idle)
            s_d.mute_q = 1'b0;
        if (!s_q.main_q[SPCC_B_MUTE])
            s_d.mute_q = 1'b0;
        else if (wr && s_q.aw_addr_q == SPCC_OFS_MAIN &&
            s_q.wdata_q[SPCC_B_MUTE] && !s_q.main_q[SPCC_B_MUTE])
            s_d.mute_q = 1'b1;
        s_d.wake_q = s_q.main_q[SPCC_B_SLEEP_WAKE_ENABLE] && clk_src_ok && en &&
            (s_q.match_q || flags.rx_ready_flag);

        // Interrupt request: OR of enabled events
        ints = (s_q.main_q[SPCC_B_RXIE] &&
            (flags.rx_ready_flag || flags.overrun_flag))
            || (s_q.main_q[SPCC_B_TX_EMPTY_IRQ_EN] && flags.tx_empty_flag)
            || (s_q.main_q[SPCC_B_TX_DONE_IRQ_EN] && flags.tx_done_flag)
            || (s_q.main_q[SPCC_B_PERIE] && flags.parity_fault_flag)
            || (s_q.main_q[SPCC_B_IDLE_IRQ_EN] && flags.idle_flag)
            || (s_q.fmt_q[SPCC_B_LBDIE] && flags.break_flag)
            || (s_q.main_q[SPCC_B_CHAR_MATCH_IRQ_EN] && flags.char_match_flag)
            || (s_q.main_q[SPCC_B_RX_TIMEOUT_IRQ_EN] && flags.timeout_flag)
            || (s_q.main_q[SPCC_B_BLOCK_END_IRQ_EN] && flags.block_end_flag);
        s_d.irq_q = ints;
        s_d.tick_q = tick_r;
        // Swapped pins turn the tx pad into an input
        s_d.oe_q = en && !s_q.fmt_q[SPCC_B_SWAP];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
            s_q.de_st_q <= SPCC_DE_IDLE;
            s_q.div_q <= SPCC_DIV_RST;
            s_q.tx_pin_q <= 1'b1;
            s_q.rx_sync_q <= 2'b11;
            s_q.rx_bit_q <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign s_axi_awready = !s_q.aw_got_q;
    assign s_axi_wready = !s_q.w_got_q;
    assign s_axi_bvalid = s_q.bvalid_q;
    assign s_axi_bresp = s_q.bresp_q;
    assign s_axi_arready = !s_q.rvalid_q;
    assign s_axi_rvalid = s_q.rvalid_q;
    assign s_axi_rdata = s_q.rdata_q;
    assign s_axi_rresp = s_q.rresp_q;
    assign tx_pin = s_q.tx_pin_q;
    assign tx_pin_oe = s_q.oe_q;
    assign rx_data_bit = s_q.rx_bit_q;
    assign ck_pin = s_q.ck_pin_q;
    assign transceiver_drive_enable = s_q.de_pin_q;
    assign tx_start_ok = s_q.tx_gate_q;
    assign irq = s_q.irq_q;
    assign sleep_wake = s_q.wake_q;
    assign mute_active = s_q.mute_q;
    assign addr_match = s_q.match_q;
    assign receiver_on = s_q.rx_on_q;
    assign sample_tick = s_q.tick_q;

    // Bit order, data invert, stop length, parity and clock phase stay
    // plain register bits for the frame engine

    property p_lead;
        @(posedge aclk) disable iff (!aresetn)
        (s_q.de_st_q == SPCC_DE_IDLE && s_d.de_st_q == SPCC_DE_LEAD)
        |=> s_q.de_cnt_q == s_q.main_q[SPCC_B_LEAD +: 5];
    endproperty
    a_lead: assert property (p_lead)
        else $error("lead count wrong");
    property p_lag;
        @(posedge aclk) disable iff (!aresetn)
        (s_q.de_st_q == SPCC_DE_LAG && s_q.de_cnt_q != 5'd0 && tick_r
        && s_q.main_q[SPCC_B_UEN]) |=> s_q.de_cnt_q == $past(s_q.de_cnt_q) - 5'd1;
    endproperty
    a_lag: assert property (p_lag) else $error("lag count wrong");
    property p_lock;
        @(posedge aclk) disable iff (!aresetn)
        (s_q.main_q[SPCC_B_UEN] && s_d.main_q[SPCC_B_UEN])
        |=> s_q.main_q[SPCC_B_OVS] == $past(s_q.main_q[SPCC_B_OVS]);
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked bit changed");
    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
        (s_q.main_q[SPCC_B_RXIE] && flags.overrun_flag) |=> s_q.irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_addr;
        @(posedge aclk) disable iff (!aresetn)
        (s_q.rx_on_q && s_q.main_q[SPCC_B_REN] && s_q.main_q[SPCC_B_UEN])
        ##1 (s_q.main_q[SPCC_B_REN] && s_q.main_q[SPCC_B_UEN])
        |-> s_q.fmt_q[31:24] == $past(s_q.fmt_q[31:24]);
    endproperty
    a_addr: assert property (p_addr)
        else $error("address changed");
    property p_de;
        @(posedge aclk) disable iff (!aresetn)
        !s_q.main_q[SPCC_B_UEN] |=> s_q.de_st_q == SPCC_DE_IDLE;
    endproperty
    a_de: assert property (p_de) else $error("drive not idle");
    property p_ck;
        @(posedge aclk) disable iff (!aresetn)
        !s_q.fmt_q[SPCC_B_CKEN] ##1 !s_q.fmt_q[SPCC_B_CKEN]
        |-> s_q.ck_pin_q == $past(s_q.fmt_q[SPCC_B_CPL]);
    endproperty
    a_ck: assert property (p_ck) else $error("clock idle level");
    property p_pol;
        @(posedge aclk) disable iff (!aresetn)
        (s_q.de_st_q == SPCC_DE_IDLE ##1 s_q.de_st_q == SPCC_DE_IDLE)
        |-> s_q.de_pin_q == $past(s_q.ext_q[SPCC_B_DPOL]);
    endproperty
    a_pol: assert property (p_pol) else $error("drive polarity");
endmodule : spcc_top

// file: bench/spcc_remote.sv
// Remote transceiver model on the line side of the port
`timescale 1ns/1ps
module spcc_remote (
    input wire logic send_en,
    input wire logic send_lvl,
    input wire logic far_lvl,
    input wire logic dev_tx,
    input wire logic dev_tx_oe,
    output logic line_rx,
    output logic line_tx
);
    // Released receive line rests high through its pull-up
    assign line_rx = send_en ? send_lvl : 1'b1;
    // Shared wire: the device wins while it drives, else the remote
    assign line_tx = dev_tx_oe ? dev_tx : far_lvl;
endmodule : spcc_remote

// file: bench/tb_serial_port_control_config.sv
// Testbench for the serial port control and configuration block
`timescale 1ns/1ps
module tb_serial_port_control_config;
    import spcc_pkg::*;
    typedef struct packed
    {logic [3:0] a; logic [31:0] d; logic [9:0] f; logic e;} spcc_row_type;
    logic aclk = 0, aresetn = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, tx_pin, tx_pin_oe, rx_data_bit, ck_pin;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] flags = 0;
    logic [15:0] bit_divider = 16'h0020;
    logic clk_src_ok = 0, tx_frame_req = 0, tx_frame_busy = 0;
    logic tx_serial_bit = 1, sync_clk_raw = 0, rx_frame_done = 0;
    logic [8:0] rx_frame_data = 0;
    logic line_idle = 1, send_en = 0, send_lvl = 1, far_lvl = 1;
    logic rx_pin, tx_pin_in, transceiver_drive_enable, tx_start_ok, irq;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    spcc_row_type rows [12] = '{
        '{4'h0, 32'h20, 10'h200, 1'b1}, '{4'h0, 32'h20, 10'h100, 1'b1},
        '{4'h0, 32'h80, 10'h080, 1'b1}, '{4'h0, 32'h40, 10'h040, 1'b1},
        '{4'h0, 32'h100, 10'h020, 1'b1}, '{4'h0, 32'h10, 10'h010, 1'b1},
        '{4'h4, 32'h40, 10'h008, 1'b1}, '{4'h0, 32'h4000, 10'h004, 1'b1},
        '{4'h0, 32'h0400_0000, 10'h002, 1'b1},
        '{4'h0, 32'h0800_0000, 10'h001, 1'b1},
        '{4'h0, 32'h20, 10'h080, 1'b0}, '{4'h0, 32'h0, 10'h3ff, 1'b0}};
    spcc_top uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .flags(flags),
        .bit_divider(bit_divider), .clk_src_ok(clk_src_ok),
        .tx_frame_req(tx_frame_req), .tx_frame_busy(tx_frame_busy),
        .tx_serial_bit(tx_serial_bit), .sync_clk_raw(sync_clk_raw),
        .rx_frame_done(rx_frame_done), .rx_frame_data(rx_frame_data),
        .line_idle(line_idle), .rx_pin(rx_pin), .tx_pin_in(tx_pin_in),
        .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe), .rx_data_bit(rx_data_bit),
        .ck_pin(ck_pin), .transceiver_drive_enable(transceiver_drive_enable),
        .tx_start_ok(tx_start_ok), .irq(irq), .sleep_wake(),
        .mute_active(), .addr_match(), .receiver_on(), .sample_tick());
    spcc_remote far_end (.send_en(send_en), .send_lvl(send_lvl),
        .far_lvl(far_lvl), .dev_tx(tx_pin), .dev_tx_oe(tx_pin_oe),
        .line_rx(rx_pin), .line_tx(tx_pin_in));
    always #12.5 aclk = ~aclk;
    task automatic wrap_up;
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // Hang guard: the whole run needs under a thousand cycles
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        tests_run++;
        if (s !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Decisions at the falling edge see what the rising edge samples
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw, w, b;
        b = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b)
        begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ar, v;
        v = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!v)
        begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (v) s_axi_rready <= 1'b0;
        end
    endtask : rd
    function automatic logic [31:0] lk(input logic [31:0] o, n, m, l);
        return (o & l) | (n & m & ~l);
    endfunction : lk
    // Two main writes: the first drops the enable that locks the rest
    task automatic clr;
        logic [1:0] r;
        wr(4'h0, 32'h0, r);
        wr(4'h0, 32'h0, r);
        wr(4'h4, 32'h0, r);
        wr(4'h8, 32'h0, r);
    endtask : clr
    task automatic wrd(input logic [3:0] a, input logic [31:0] d, e);
        logic [31:0] q;
        logic [1:0] r;
        wr(a, d, r);
        rd(a, q, r);
        chk("reg", q, e);
    endtask : wrd
    task automatic de_run(input logic ovs, input int tp);
        int c;
        logic [1:0] r;
        wr(4'h8, 32'h4000, r);
        wr(4'h0, {6'h0, 5'd4, 5'd3, ovs, 15'h8}, r);
        wr(4'h0, {6'h0, 5'd4, 5'd3, ovs, 15'h9}, r);
        tx_frame_req <= 1'b1;
        @(negedge aclk);
        while (transceiver_drive_enable !== 1'b1) @(negedge aclk);
        c = 0;
        while (tx_start_ok !== 1'b1)
        begin
            @(negedge aclk);
            c++;
        end
        chk("lead", c >= 4 * tp - 1 && c <= 5 * tp + 3, 1);
        @(posedge aclk);
        tx_frame_req <= 1'b0;
        tx_frame_busy <= 1'b1;
        repeat (4) @(posedge aclk);
        tx_frame_busy <= 1'b0;
        @(negedge aclk);
        c = 0;
        while (transceiver_drive_enable === 1'b1)
        begin
            @(negedge aclk);
            c++;
        end
        chk("lag", c >= 3 * tp - 1 && c <= 4 * tp + 3, 1);
        clr();
    endtask : de_run
    initial
    begin
        logic [31:0] q;
        logic [1:0] r;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            clr();
            wr(rows[i].a, rows[i].d, r);
            flags <= rows[i].f;
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            chk("irq", irq, rows[i].e);
            @(posedge aclk);
            flags <= 10'h0;
        end
        // Mid-run reset must bring back the reset values
        wr(4'h4, 32'hffff_ffff, r);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            rd(4'(i * 4), q, r);
            chk("reset", q, SPCC_RST_VAL);
        end
        wrd(4'h0, 32'hffff_fffe, SPCC_MAIN_MASK & 32'hffff_fffe);
        wrd(4'h4, 32'hffff_ffff, SPCC_FMT_MASK);
        wrd(4'h8, 32'hffff_ffff, SPCC_EXT_MASK);
        clr();
        wrd(4'h0, 32'h1, 32'h1);
        q = lk(32'h0, 32'hffff_ffff, SPCC_FMT_MASK, SPCC_FMT_LOCK);
        wrd(4'h4, 32'hffff_ffff, q);
        wrd(4'h0, 32'hffff_ffff,
            lk(32'h1, 32'hffff_ffff, SPCC_MAIN_MASK, SPCC_MAIN_LOCK));
        wrd(4'h4, 32'h0,
            lk(q, 32'h0, SPCC_FMT_MASK, SPCC_FMT_LOCK | SPCC_ADDR_FIELD));
        wrd(4'h8, 32'hffff_ffff,
            lk(32'h0, 32'hffff_ffff, SPCC_EXT_MASK, SPCC_EXT_LOCK));
        wr(4'h2, 32'h1, r);
        chk("wresp", r, 2'b10);
        rd(4'h1, q, r);
        chk("rresp", r, 2'b10);
        clr();
        de_run(1'b0, 2);
        de_run(1'b1, 4);
        // Word length 9, break 11, clock pin on and idle high, tx inverted
        wr(4'h0, 32'h1000, r);
        wr(4'h4, 32'h0002_0c20, r);
        rd(4'hc, q, r);
        chk("decode", q[15:8], {SPCC_BRK11, SPCC_BITS9});
        wr(4'h8, 32'hc000, r);
        wr(4'h0, 32'h1, r);
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk("de_idle", transceiver_drive_enable, 1'b1);
        chk("ck_idle", ck_pin, 1'b1);
        chk("tx_lvl", tx_pin, 1'b0);
        chk("tx_oe", tx_pin_oe, 1'b1);
        clr();
        // Receive side sees the far end on the opposite level per pin
        send_en <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            clr();
            wr(4'h4, {14'h0, i[1], i[2], 15'h0}, r);
            wr(4'h0, 32'h5, r);
            send_lvl <= i[0];
            far_lvl <= ~i[0];
            repeat (6) @(posedge aclk);
            @(negedge aclk);
            chk("rx_bit", rx_data_bit, i[0] ^ i[2] ^ i[1]);
        end
        wrap_up();
    end
endmodule : tb_serial_port_control_config
